//--- rtl/lptv_voter.sv
// Low coolant pressure trip voter with AHB-Lite register slave
// Functional notes
// - New mode: each channel works on the median of three pressures.
// - Legacy mode: each channel works on its own pressure.
// - Channel trips when working pressure at or below trip setpoint.
// - Building pressure trip input also trips every channel.
// - Two or more channel trips actuate output channels 1 and 2.
// - Pressure at or above removal setpoint clears channel bypass.
// - Bypass request accepted only at or below permit setpoint.
// - Removal re-arms only after pressure falls to permit setpoint.
// - All setpoints live in software-writable registers.
// - Bypass in two channels suppresses low-pressure actuation.
// - Bypass never blocks building pressure actuation.
`timescale 1ns/1ps
`include "lptv_regs.svh"
module lptv_voter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire lptv_pkg::lptv_press_t channel_pressure_a,
   input wire lptv_pkg::lptv_press_t channel_pressure_b,
   input wire lptv_pkg::lptv_press_t channel_pressure_c,
   input wire logic building_pressure_trip,
   input wire logic [2:0] bypass_button,
   output logic [2:0] channel_trip,
   output logic [2:0] bypass_lamp,
   output logic actuation_1,
   output logic actuation_2,
   output logic irq
);
   import lptv_pkg::*;

   function automatic lptv_press_t median3(input lptv_press_t a, input lptv_press_t b,
                                           input lptv_press_t c);
      lptv_press_t lo;
      lptv_press_t hi;
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      median3 = (c <= lo) ? lo : ((c >= hi) ? hi : c);
   endfunction

   // Two or more of three set
   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // Keeps the last word seen twice in a row
   function automatic lptv_press_t settled(input lptv_press_t cur, input lptv_press_t prev,
                                           input lptv_press_t kept);
      settled = (cur == prev) ? cur : kept;
   endfunction

   // Pin synchronisers: pressures and buttons come from outside the clock domain
   lptv_press_t pa_s1, pb_s1, pc_s1, pa_s2, pb_s2, pc_s2;
   logic bld_s1, bld_s2;
   logic [2:0] btn_s1, btn_s2, btn_d;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_s1 <= 12'h000;
         pb_s1 <= 12'h000;
         pc_s1 <= 12'h000;
         pa_s2 <= 12'h000;
         pb_s2 <= 12'h000;
         pc_s2 <= 12'h000;
         bld_s1 <= 1'b0;
         bld_s2 <= 1'b0;
         btn_s1 <= 3'h0;
         btn_s2 <= 3'h0;
         btn_d <= 3'h0;
      end else begin
         pa_s1 <= channel_pressure_a;
         pb_s1 <= channel_pressure_b;
         pc_s1 <= channel_pressure_c;
         pa_s2 <= pa_s1;
         pb_s2 <= pb_s1;
         pc_s2 <= pc_s1;
         bld_s1 <= building_pressure_trip;
         bld_s2 <= bld_s1;
         btn_s1 <= bypass_button;
         btn_s2 <= btn_s1;
         btn_d <= btn_s2;
      end
   end

   // Pressure words cross bit by bit, so one caught mid-update may mix old and new bits.
   // Only a word seen in two samples in a row is used; costs two cycles of latency,
   // and a word that changes on every cycle is never taken.
   lptv_press_t pa_s3, pb_s3, pc_s3, pa_ok, pb_ok, pc_ok;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_s3 <= 12'h000;
         pb_s3 <= 12'h000;
         pc_s3 <= 12'h000;
         pa_ok <= 12'h000;
         pb_ok <= 12'h000;
         pc_ok <= 12'h000;
      end else begin
         pa_s3 <= pa_s2;
         pb_s3 <= pb_s2;
         pc_s3 <= pc_s2;
         pa_ok <= settled(pa_s2, pa_s3, pa_ok);
         pb_ok <= settled(pb_s2, pb_s3, pb_ok);
         pc_ok <= settled(pc_s2, pc_s3, pc_ok);
      end
   end

   // Registers
   lptv_mode_e mode;
   lptv_press_t trip_setpoint, bypass_removal_setpoint, bypass_permit_setpoint, auto_reset_value;
   logic [2:0] irq_stat, irq_mask, sw_byp_req;
   logic [2:0] low_trip, bypass, removal_armed;
   logic act_q;

   // AHB-Lite address phase capture
   // Zero wait states; a write lands at the end of its data phase
   logic wr_pend;
   logic [11:0] addr_q;
   wire take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_pend <= take & hwrite;
         if (take) begin
            addr_q <= haddr;
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire wr_ctrl = wr_pend && addr_q == `LPTV_CTRL_OFF;
   wire wr_trip = wr_pend && addr_q == `LPTV_TRIP_SP_OFF;
   wire wr_rbyp = wr_pend && addr_q == `LPTV_RBYP_SP_OFF;
   wire wr_byp = wr_pend && addr_q == `LPTV_BYP_SP_OFF;
   wire wr_arst = wr_pend && addr_q == `LPTV_ARST_OFF;
   wire wr_istat = wr_pend && addr_q == `LPTV_IRQ_STAT_OFF;
   wire wr_imask = wr_pend && addr_q == `LPTV_IRQ_MASK_OFF;
   wire wr_breq = wr_pend && addr_q == `LPTV_BYP_REQ_OFF;

   // Working pressure selection
   // Legacy mode uses each channel's own word, median mode the middle one of three;
   // both see only filtered words
   wire lptv_press_t med = median3(pa_ok, pb_ok, pc_ok);
   lptv_press_t work [3];
   assign work[0] = (mode == LPTV_MEDIAN) ? med : pa_ok;
   assign work[1] = (mode == LPTV_MEDIAN) ? med : pb_ok;
   assign work[2] = (mode == LPTV_MEDIAN) ? med : pc_ok;

   // Per-channel comparators
   logic [2:0] at_trip, above_reset, at_removal, at_permit, byp_req, byp_accept, next_low_trip;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         at_trip[i] = work[i] <= trip_setpoint;
         above_reset[i] = work[i] > auto_reset_value;
         at_removal[i] = work[i] >= bypass_removal_setpoint;
         at_permit[i] = work[i] <= bypass_permit_setpoint;
         byp_req[i] = (btn_s2[i] & ~btn_d[i]) | (wr_breq & hwdata[i]);
         byp_accept[i] = byp_req[i] & at_permit[i] & ~at_removal[i];
         // Legacy comparator follows pressure; new mode holds until auto-reset value
         if (mode == LPTV_MEDIAN) begin
            next_low_trip[i] = at_trip[i] | (low_trip[i] & ~above_reset[i]);
         end else begin
            next_low_trip[i] = at_trip[i];
         end
      end
   end

   // Low-pressure trips count only where not bypassed; building trip always counts
   wire [2:0] eff_low = low_trip & ~bypass;
   wire [2:0] trip_vec = eff_low | {3{bld_s2}};
   // Two bypassed channels leave at most one low trip in the vote, which
   // suppresses low-pressure actuation while building trips still count
   wire vote = maj3(trip_vec);

   logic [2:0] next_bypass, next_armed, byp_set_ev, byp_clr_ev;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Removal fires once per rise; re-armed only by falling to permit level
         byp_clr_ev[i] = bypass[i] & at_removal[i] & removal_armed[i];
         byp_set_ev[i] = byp_accept[i] & ~bypass[i];
         next_bypass[i] = (bypass[i] | byp_accept[i]) & ~byp_clr_ev[i];
         if (at_permit[i]) begin
            next_armed[i] = 1'b1;
         end else if (byp_clr_ev[i]) begin
            next_armed[i] = 1'b0;
         end else begin
            next_armed[i] = removal_armed[i];
         end
      end
   end

   wire act_rise = vote & ~act_q;
   wire [2:0] irq_ev = {|byp_clr_ev, |byp_set_ev, act_rise};
   // Set wins over a simultaneous write-one clear
   wire [2:0] next_irq_stat = (irq_stat & ~(wr_istat ? hwdata[2:0] : 3'h0)) | irq_ev;

   // Software-writable setpoints and mode, retunable in service
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= LPTV_LEGACY;
         trip_setpoint <= `LPTV_TRIP_SP_RST;
         bypass_removal_setpoint <= `LPTV_RBYP_SP_RST;
         bypass_permit_setpoint <= `LPTV_BYP_SP_RST;
         auto_reset_value <= `LPTV_ARST_RST;
         irq_mask <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            mode <= lptv_mode_e'(hwdata[`LPTV_CTRL_MODE_BIT]);
         end
         if (wr_trip) begin
            trip_setpoint <= hwdata[11:0];
         end
         if (wr_rbyp) begin
            bypass_removal_setpoint <= hwdata[11:0];
         end
         if (wr_byp) begin
            bypass_permit_setpoint <= hwdata[11:0];
         end
         if (wr_arst) begin
            auto_reset_value <= hwdata[11:0];
         end
         if (wr_imask) begin
            irq_mask <= hwdata[2:0];
         end
      end
   end

   // Sticky event flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   // Channel trip, bypass and actuation state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_trip <= 3'h0;
         bypass <= 3'h0;
         removal_armed <= 3'h7;
         act_q <= 1'b0;
      end else begin
         low_trip <= next_low_trip;
         bypass <= next_bypass;
         removal_armed <= next_armed;
         act_q <= vote;
      end
   end

   assign channel_trip = trip_vec;
   assign bypass_lamp = bypass;
   assign actuation_1 = act_q;
   assign actuation_2 = act_q;
   assign irq = |(irq_stat & irq_mask);

   // Read data is latched at the end of the address phase, so a read returns the
   // register as it stood then; zero outside a read data phase
   wire [31:0] status_word = {25'h0, act_q, bypass, trip_vec};
   logic [31:0] rd_word;
   always_comb begin
      if (haddr == `LPTV_CTRL_OFF) begin
         rd_word = {31'h0, mode == LPTV_MEDIAN};
      end else if (haddr == `LPTV_TRIP_SP_OFF) begin
         rd_word = {20'h0, trip_setpoint};
      end else if (haddr == `LPTV_RBYP_SP_OFF) begin
         rd_word = {20'h0, bypass_removal_setpoint};
      end else if (haddr == `LPTV_BYP_SP_OFF) begin
         rd_word = {20'h0, bypass_permit_setpoint};
      end else if (haddr == `LPTV_ARST_OFF) begin
         rd_word = {20'h0, auto_reset_value};
      end else if (haddr == `LPTV_STATUS_OFF) begin
         rd_word = status_word;
      end else if (haddr == `LPTV_IRQ_STAT_OFF) begin
         rd_word = {29'h0, irq_stat};
      end else if (haddr == `LPTV_IRQ_MASK_OFF) begin
         rd_word = {29'h0, irq_mask};
      end else if (haddr == `LPTV_BYP_REQ_OFF) begin
         rd_word = {29'h0, bypass};
      end else begin
         rd_word = 32'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else begin
         hrdata <= (take & ~hwrite) ? rd_word : 32'h0;
      end
   end
endmodule

//--- shared/lptv_regs.svh
// Register offsets, field positions and reset values of the low pressure trip voter
`ifndef LPTV_REGS_SVH
`define LPTV_REGS_SVH
`define LPTV_CTRL_OFF 12'h000
`define LPTV_TRIP_SP_OFF 12'h004
`define LPTV_RBYP_SP_OFF 12'h008
`define LPTV_BYP_SP_OFF 12'h00c
`define LPTV_ARST_OFF 12'h010
`define LPTV_STATUS_OFF 12'h014
`define LPTV_IRQ_STAT_OFF 12'h018
`define LPTV_IRQ_MASK_OFF 12'h01c
`define LPTV_BYP_REQ_OFF 12'h020
`define LPTV_CTRL_MODE_BIT 0
`define LPTV_TRIP_SP_RST 12'h640
`define LPTV_RBYP_SP_RST 12'h6cc
`define LPTV_BYP_SP_RST 12'h6cc
`define LPTV_ARST_RST 12'h64a
`define LPTV_ST_TRIP_LSB 0
`define LPTV_ST_BYP_LSB 3
`define LPTV_ST_ACT_BIT 6
`define LPTV_IRQ_ACT_BIT 0
`define LPTV_IRQ_BYPSET_BIT 1
`define LPTV_IRQ_BYPCLR_BIT 2
`endif

//--- shared/lptv_pkg.sv
// Types of the low pressure trip voter
package lptv_pkg;
   typedef logic [11:0] lptv_press_t;
   typedef enum logic {LPTV_LEGACY, LPTV_MEDIAN} lptv_mode_e;
endpackage

//--- verification/lptv_plant.sv
// Transmitter and pushbutton model on the field side of the voter
`timescale 1ns/1ps
module lptv_plant (
   input wire logic hclk,
   input wire lptv_pkg::lptv_press_t set_a,
   input wire lptv_pkg::lptv_press_t set_b,
   input wire lptv_pkg::lptv_press_t set_c,
   input wire logic [2:0] press,
   output lptv_pkg::lptv_press_t channel_pressure_a,
   output lptv_pkg::lptv_press_t channel_pressure_b,
   output lptv_pkg::lptv_press_t channel_pressure_c,
   output logic [2:0] bypass_button
);
   import lptv_pkg::*;
   localparam lptv_press_t PMAX = 12'h9c4;
   // Transmitters saturate at full scale
   always_ff @(posedge hclk) begin
      channel_pressure_a <= (set_a > PMAX) ? PMAX : set_a;
      channel_pressure_b <= (set_b > PMAX) ? PMAX : set_b;
      channel_pressure_c <= (set_c > PMAX) ? PMAX : set_c;
      bypass_button <= press;
   end
endmodule

//--- verification/lptv_voter_asserts.sv
// Port assertions for the low pressure trip voter
`timescale 1ns/1ps
module lptv_voter_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire lptv_pkg::lptv_press_t channel_pressure_a,
   input wire lptv_pkg::lptv_press_t channel_pressure_b,
   input wire lptv_pkg::lptv_press_t channel_pressure_c,
   input wire logic building_pressure_trip,
   input wire logic [2:0] channel_trip,
   input wire logic [2:0] bypass_lamp,
   input wire logic actuation_1,
   input wire logic actuation_2
);
   import lptv_pkg::*;
   logic dph;
   wire zero_all = (channel_pressure_a == 12'h0) && (channel_pressure_b == 12'h0)
      && (channel_pressure_c == 12'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph <= 1'b0;
      end else begin
         dph <= hsel && hready && htrans[1];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_vote_fire: assert property ($countones(channel_trip) >= 2 |=> actuation_1)
      else $error("no actuation after two trips");
   a_vote_quiet: assert property ($countones(channel_trip) < 2 |=> !actuation_1)
      else $error("actuation without two trips");
   a_act_pair: assert property (actuation_1 == actuation_2)
      else $error("actuation outputs differ");
   a_bldg_all: assert property (building_pressure_trip [*4] |-> channel_trip == 3'h7)
      else $error("building trip not on every channel");
   a_zero_trip: assert property ((zero_all && bypass_lamp == 3'h0) [*6] |-> channel_trip == 3'h7)
      else $error("zero pressure without trip");
   a_byp_masks: assert property (|(channel_trip & bypass_lamp) |->
      $past(building_pressure_trip, 2) || $past(building_pressure_trip, 3)
      || $past(building_pressure_trip, 4))
      else $error("bypassed channel tripped on pressure");
   a_rdata_idle: assert property (!dph |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("wait state or error response");
endmodule
bind lptv_voter lptv_voter_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .channel_pressure_a(channel_pressure_a), .channel_pressure_b(channel_pressure_b),
   .channel_pressure_c(channel_pressure_c), .building_pressure_trip(building_pressure_trip),
   .channel_trip(channel_trip), .bypass_lamp(bypass_lamp), .actuation_1(actuation_1),
   .actuation_2(actuation_2));

//--- verification/tb_top.sv
// Register and pin level testbench for the low pressure trip voter
`timescale 1ns/1ps
`include "lptv_regs.svh"
module tb_top;
   import lptv_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic building_pressure_trip = 1'b0;
   logic [2:0] press = 3'h0;
   lptv_press_t set_a = 12'h0, set_b = 12'h0, set_c = 12'h0;
   lptv_press_t pa, pb, pc;
   logic [31:0] hrdata;
   logic hreadyout, hresp, actuation_1, actuation_2, irq;
   logic [2:0] channel_trip, bypass_lamp, bypass_button;
   int n_errors = 0;
   int cmp_count = 0;
   wire [7:0] pins = {actuation_2, actuation_1, bypass_lamp, channel_trip};
   lptv_plant i_plant (.hclk(hclk), .set_a(set_a), .set_b(set_b), .set_c(set_c), .press(press),
      .channel_pressure_a(pa), .channel_pressure_b(pb), .channel_pressure_c(pc),
      .bypass_button(bypass_button));
   lptv_voter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .channel_pressure_a(pa), .channel_pressure_b(pb),
      .channel_pressure_c(pc), .building_pressure_trip(building_pressure_trip),
      .bypass_button(bypass_button), .channel_trip(channel_trip), .bypass_lamp(bypass_lamp),
      .actuation_1(actuation_1), .actuation_2(actuation_2), .irq(irq));
   initial begin
      forever #50 hclk = ~hclk;
   end
   task automatic summarize;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits end only on hreadyout or by the watchdog, never by a cycle count
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      @(posedge hclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // Nine edges cover plant, sync, word filter and vote latency
   task automatic pr(input lptv_press_t a, input lptv_press_t b, input lptv_press_t c,
      input logic [7:0] e);
      set_a <= a;
      set_b <= b;
      set_c <= c;
      repeat (9) @(posedge hclk);
      chk({24'h0, pins}, {24'h0, e});
   endtask
   task automatic push(input logic [2:0] m, input logic [7:0] e);
      press <= m;
      repeat (7) @(posedge hclk);
      press <= 3'h0;
      repeat (2) @(posedge hclk);
      chk({24'h0, pins}, {24'h0, e});
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      pr(12'h0, 12'h0, 12'h0, 8'hc7);
      rd(`LPTV_TRIP_SP_OFF, 32'h640);
      rd(`LPTV_RBYP_SP_OFF, 32'h6cc);
      rd(`LPTV_BYP_SP_OFF, 32'h6cc);
      rd(`LPTV_ARST_OFF, 32'h64a);
      wr(12'h100, 32'h5);
      rd(12'h100, 32'h0);
      pr(12'h640, 12'h641, 12'h7d0, 8'h01);
      pr(12'h640, 12'h640, 12'h7d0, 8'hc3);
      rd(`LPTV_STATUS_OFF, 32'h43);
      wr(`LPTV_IRQ_MASK_OFF, 32'h1);
      wr(`LPTV_IRQ_STAT_OFF, 32'h7);
      chk({31'h0, irq}, 32'h0);
      pr(12'h7d0, 12'h7d0, 12'h7d0, 8'h00);
      pr(12'h5dc, 12'h5dc, 12'h7d0, 8'hc3);
      chk({31'h0, irq}, 32'h1);
      rd(`LPTV_IRQ_STAT_OFF, 32'h1);
      wr(`LPTV_IRQ_MASK_OFF, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`LPTV_IRQ_STAT_OFF, 32'h1);
      rd(`LPTV_IRQ_STAT_OFF, 32'h0);
      wr(`LPTV_TRIP_SP_OFF, 32'h5dc);
      rd(`LPTV_TRIP_SP_OFF, 32'h5dc);
      pr(12'h60e, 12'h60e, 12'h7d0, 8'h00);
      wr(`LPTV_TRIP_SP_OFF, 32'h640);
      wr(`LPTV_CTRL_OFF, 32'h1);
      rd(`LPTV_CTRL_OFF, 32'h1);
      pr(12'h3e8, 12'h7d0, 12'h7d0, 8'h00);
      pr(12'h3e8, 12'h5dc, 12'h7d0, 8'hc7);
      pr(12'h3e8, 12'h645, 12'h7d0, 8'hc7);
      pr(12'h3e8, 12'h64b, 12'h7d0, 8'h00);
      pr(12'h7d0, 12'h7d0, 12'h7d0, 8'h00);
      push(3'h1, 8'h00);
      pr(12'h6a4, 12'h6a4, 12'h6a4, 8'h00);
      push(3'h1, 8'h08);
      pr(12'h6cc, 12'h6cc, 12'h6cc, 8'h00);
      pr(12'h6a4, 12'h6a4, 12'h6a4, 8'h00);
      rd(`LPTV_IRQ_STAT_OFF, 32'h7);
      wr(`LPTV_BYP_REQ_OFF, 32'h3);
      rd(`LPTV_BYP_REQ_OFF, 32'h3);
      pr(12'h5dc, 12'h5dc, 12'h5dc, 8'h1c);
      building_pressure_trip <= 1'b1;
      pr(12'h5dc, 12'h5dc, 12'h5dc, 8'hdf);
      summarize();
   end
endmodule
